// [verilog/ptc_pkg.sv]
// Package: constants, register map and types for the radio control handshake block
`default_nettype none
package ptc_pkg;
	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int BYTE_W = 8;
	localparam int LEN_W  = 12;
	localparam int RATE_W = 5;
	localparam int TFC_W  = 3;
	localparam int HDR_W  = 80;
	localparam int EV_N   = 8;
	localparam int CMD_N  = 5;
	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RXV0   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RXV1   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_HDR0   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_HDR1   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_HDR2   = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_TMO    = 8'h1c;
	////////////////////////////////////////////////////////////////////////
	// Command bits in the control register
	localparam int CMD_TX_END    = 0;
	localparam int CMD_RX_START  = 1;
	localparam int CMD_RX_END    = 2;
	localparam int CMD_CCA_START = 3;
	localparam int CMD_CCA_END   = 4;
	// Sticky event bits in the status register
	localparam int EV_TX_END_CFM   = 0;
	localparam int EV_RX_START_IND = 1;
	localparam int EV_RX_START_CFM = 2;
	localparam int EV_RX_TMO       = 3;
	localparam int EV_RX_END_IND   = 4;
	localparam int EV_RX_END_CFM   = 5;
	localparam int EV_CCA_STA_CFM  = 6;
	localparam int EV_CCA_END_CFM  = 7;
	// Live status bits
	localparam int ST_CHAN    = 8;
	localparam int ST_CCA_RUN = 9;
	localparam int ST_RX_RUN  = 10;
	localparam int ST_TX_HALT = 11;
	////////////////////////////////////////////////////////////////////////
	// Receive vector field positions
	localparam int V0_LEN   = 0;
	localparam int V0_RATE  = 12;
	localparam int V0_BURST = 17;
	localparam int V0_PRE   = 18;
	localparam int V0_TFC   = 19;
	localparam int V0_BG    = 22;
	localparam int V1_ERR   = 0;
	localparam int V1_SIG   = 8;
	localparam int V1_LQ    = 16;
	localparam int ERR_RATE_BIT = 3;
	localparam int ERR_HCS_BIT  = 4;
	// Channel status attribute values
	localparam logic CHAN_CLEAR = 1'h0;
	localparam logic CHAN_BUSY  = 1'h1;
	// Bus responses and timeout default in cycles
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [DATA_W-1:0] TMO_DEF = 32'h0000_0400;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {RX_IDLE, RX_SEEK, RX_HEAD, RX_BODY, RX_STOP} ptc_rx_t;
endpackage
`default_nettype wire

// [verilog/ptc_vec_if.sv]
// Interface: latched receive parameter vector between capture unit and top
`default_nettype none
interface ptc_vec_if;
	logic [ptc_pkg::LEN_W-1:0]  length;
	logic [ptc_pkg::RATE_W-1:0] rate;
	logic                       burst;
	logic                       pre_kind;
	logic [ptc_pkg::TFC_W-1:0]  time_freq_code;
	logic                       band_group_low_bit;
	logic [ptc_pkg::HDR_W-1:0]  frame_header_octets;
	logic [ptc_pkg::BYTE_W-1:0] err;
	logic [ptc_pkg::BYTE_W-1:0] signal_strength;
	logic [ptc_pkg::BYTE_W-1:0] link_quality;
	modport src (output length, rate, burst, pre_kind, time_freq_code, band_group_low_bit,
		frame_header_octets, err, signal_strength, link_quality);
	modport dst (input length, rate, burst, pre_kind, time_freq_code, band_group_low_bit,
		frame_header_octets, err, signal_strength, link_quality);
endinterface
`default_nettype wire

// [verilog/ptc_rxvec.sv]
// Capture unit for the receive parameter vector at header completion
`default_nettype none
module ptc_rxvec
(
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       cap,
	input  wire logic [ptc_pkg::LEN_W-1:0]  hdr_length,
	input  wire logic [ptc_pkg::RATE_W-1:0] hdr_rate,
	input  wire logic                       hdr_burst,
	input  wire logic                       hdr_pre_kind,
	input  wire logic [ptc_pkg::TFC_W-1:0]  hdr_tfc,
	input  wire logic                       hdr_bg_low,
	input  wire logic [ptc_pkg::HDR_W-1:0]  hdr_octets,
	input  wire logic                       hdr_hcs_ok,
	input  wire logic                       hdr_rate_ok,
	input  wire logic [ptc_pkg::BYTE_W-1:0] hdr_strength,
	input  wire logic [ptc_pkg::BYTE_W-1:0] hdr_quality,
	ptc_vec_if.src                          vec
);
	import ptc_pkg::*;

	logic [BYTE_W-1:0] err_nxt;

	always_comb
	begin
		err_nxt = '0;
		err_nxt[ERR_HCS_BIT] = ~hdr_hcs_ok;
		err_nxt[ERR_RATE_BIT] = ~hdr_rate_ok;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			vec.length <= '0;
			vec.rate <= '0;
			vec.burst <= 1'b0;
			vec.pre_kind <= 1'b0;
			vec.time_freq_code <= '0;
			vec.band_group_low_bit <= 1'b0;
			vec.frame_header_octets <= '0;
			vec.err <= '0;
			vec.signal_strength <= '0;
			vec.link_quality <= '0;
		end
		else if (cap)
		begin
			vec.length <= hdr_length;
			vec.rate <= hdr_rate;
			vec.burst <= hdr_burst;
			vec.pre_kind <= hdr_burst & hdr_pre_kind;
			vec.time_freq_code <= hdr_tfc;
			vec.band_group_low_bit <= hdr_bg_low;
			vec.frame_header_octets <= hdr_octets;
			vec.err <= err_nxt;
			vec.signal_strength <= hdr_strength;
			vec.link_quality <= hdr_quality;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_err_zero: assert property (@(posedge clk) disable iff (rst)
		cap && hdr_hcs_ok && hdr_rate_ok |=> vec.err == '0)
		else $error("header error byte not zero for good header");
	a_err_bits: assert property (@(posedge clk) disable iff (rst)
		cap |=> vec.err[ERR_HCS_BIT] == !$past(hdr_hcs_ok)
			&& vec.err[ERR_RATE_BIT] == !$past(hdr_rate_ok))
		else $error("header error bits wrong");
	a_pre_rsv: assert property (@(posedge clk) disable iff (rst)
		cap && !hdr_burst |=> !vec.pre_kind)
		else $error("preamble kind set outside burst");
	a_vec_hold: assert property (@(posedge clk) disable iff (rst)
		!cap |=> $stable(vec.length) && $stable(vec.rate))
		else $error("vector changed without capture");
endmodule
`default_nettype wire

// [verilog/ptc_ctrl.sv]
// Top: transmit end, receive sequence and channel assessment control with AXI4-Lite registers
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
module ptc_ctrl
#(
	parameter logic [ptc_pkg::DATA_W-1:0] HDR_TMO_CYC = ptc_pkg::TMO_DEF
)
(
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [ptc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [ptc_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [ptc_pkg::STRB_W-1:0] s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ptc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [ptc_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic                            tx_halt,
	input  wire logic                       tx_quiet,
	output logic                            rx_search,
	input  wire logic                       pre_sync,
	input  wire logic                       hdr_done,
	input  wire logic [ptc_pkg::LEN_W-1:0]  hdr_length,
	input  wire logic [ptc_pkg::RATE_W-1:0] hdr_rate,
	input  wire logic                       hdr_burst,
	input  wire logic                       hdr_pre_kind,
	input  wire logic [ptc_pkg::TFC_W-1:0]  hdr_tfc,
	input  wire logic                       hdr_bg_low,
	input  wire logic [ptc_pkg::HDR_W-1:0]  hdr_octets,
	input  wire logic                       hdr_hcs_ok,
	input  wire logic                       hdr_rate_ok,
	input  wire logic [ptc_pkg::BYTE_W-1:0] hdr_strength,
	input  wire logic [ptc_pkg::BYTE_W-1:0] hdr_quality,
	input  wire logic                       frame_done,
	input  wire logic                       rx_quiet,
	output logic                            cca_run,
	input  wire logic                       cca_busy
);
	import ptc_pkg::*;

	logic              wr_go;
	logic              rd_go;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [1:0]        rresp_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rd_word;
	logic              wr_ctrl;
	logic              wr_stat;
	logic              wr_tmo;
	logic [CMD_N-1:0]  cmd;
	logic [EV_N-1:0]   ev;
	logic [EV_N-1:0]   st_clr;
	logic [EV_N-1:0]   sticky_r;
	logic [DATA_W-1:0] tmo_cfg_r;
	logic [DATA_W-1:0] tmo_cnt_r;
	logic              expire;
	logic              tmo_load;
	logic              tx_halt_r;
	ptc_rx_t           rx_st_r;
	ptc_rx_t           rx_nxt;
	logic              e_rsi;
	logic              e_rsc;
	logic              e_tmo;
	logic              e_rei;
	logic              e_rec;
	logic              cap;
	logic              cca_run_r;
	logic              cca_sta_pend_r;
	logic              cca_end_pend_r;
	logic              chan_r;

	ptc_vec_if vec ();

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_RXV0)
			|| (a == OFF_RXV1) || (a == OFF_HDR0) || (a == OFF_HDR1)
			|| (a == OFF_HDR2) || (a == OFF_TMO);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: write takes address and data together
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	assign rd_go = s_axi_arvalid && !rvalid_r;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= addr_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
		end
		else if (rd_go)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_r <= rd_word;
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// Read multiplexer; unused bits read as zero
	always_comb
	begin
		rd_word = '0;
		case (s_axi_araddr)
			OFF_STATUS:
			begin
				rd_word[EV_N-1:0] = sticky_r;
				rd_word[ST_CHAN] = chan_r;
				rd_word[ST_CCA_RUN] = cca_run_r;
				rd_word[ST_RX_RUN] = rx_search;
				rd_word[ST_TX_HALT] = tx_halt_r;
			end
			OFF_RXV0:
			begin
				rd_word[V0_LEN +: LEN_W] = vec.length;
				rd_word[V0_RATE +: RATE_W] = vec.rate;
				rd_word[V0_BURST] = vec.burst;
				rd_word[V0_PRE] = vec.pre_kind;
				rd_word[V0_TFC +: TFC_W] = vec.time_freq_code;
				rd_word[V0_BG] = vec.band_group_low_bit;
			end
			OFF_RXV1:
			begin
				rd_word[V1_ERR +: BYTE_W] = vec.err;
				rd_word[V1_SIG +: BYTE_W] = vec.signal_strength;
				rd_word[V1_LQ +: BYTE_W] = vec.link_quality;
			end
			OFF_HDR0: rd_word = vec.frame_header_octets[0 +: DATA_W];
			OFF_HDR1: rd_word = vec.frame_header_octets[DATA_W +: DATA_W];
			OFF_HDR2: rd_word[HDR_W-2*DATA_W-1:0] = vec.frame_header_octets[HDR_W-1:2*DATA_W];
			OFF_TMO: rd_word = tmo_cfg_r;
			default: rd_word = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes: commands, status clear, timeout
	assign wr_ctrl = wr_go && (s_axi_awaddr == OFF_CTRL) && s_axi_wstrb[0];
	assign wr_stat = wr_go && (s_axi_awaddr == OFF_STATUS) && s_axi_wstrb[0];
	assign wr_tmo = wr_go && (s_axi_awaddr == OFF_TMO);
	assign cmd = wr_ctrl ? s_axi_wdata[CMD_N-1:0] : '0;
	assign st_clr = wr_stat ? s_axi_wdata[EV_N-1:0] : '0;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tmo_cfg_r <= HDR_TMO_CYC;
		else
			for (int b = 0; b < STRB_W; b++)
				if (wr_tmo && s_axi_wstrb[b])
					tmo_cfg_r[b*BYTE_W +: BYTE_W] <= s_axi_wdata[b*BYTE_W +: BYTE_W];
	end

	// Sticky events, set wins over clear
	for (genvar i = 0; i < EV_N; i++)
	begin : g_sticky
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
				sticky_r[i] <= 1'b0;
			else
				sticky_r[i] <= ev[i] | (sticky_r[i] & ~st_clr[i]);
		end
	end

	assign ev[EV_TX_END_CFM] = tx_halt_r && tx_quiet;
	assign ev[EV_RX_START_IND] = e_rsi;
	assign ev[EV_RX_START_CFM] = e_rsc;
	assign ev[EV_RX_TMO] = e_tmo;
	assign ev[EV_RX_END_IND] = e_rei;
	assign ev[EV_RX_END_CFM] = e_rec;
	assign ev[EV_CCA_STA_CFM] = cca_sta_pend_r && cca_run_r;
	assign ev[EV_CCA_END_CFM] = cca_end_pend_r && !cca_run_r;

	////////////////////////////////////////////////////////////////////////
	// Transmit end
	// halt until quiet
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tx_halt_r <= 1'b0;
		else if (cmd[CMD_TX_END])
			tx_halt_r <= 1'b1;
		else if (tx_quiet)
			tx_halt_r <= 1'b0;
	end
	assign tx_halt = tx_halt_r;

	////////////////////////////////////////////////////////////////////////
	// Receive sequence; end request has priority
	always_comb
	begin
		rx_nxt = rx_st_r;
		e_rsi = 1'b0;
		e_rsc = 1'b0;
		e_tmo = 1'b0;
		e_rei = 1'b0;
		e_rec = 1'b0;
		cap = 1'b0;
		case (rx_st_r)
			RX_IDLE:
				if (cmd[CMD_RX_END])
					rx_nxt = RX_STOP;
				else if (cmd[CMD_RX_START])
					rx_nxt = RX_SEEK;
			RX_SEEK:
				if (cmd[CMD_RX_END])
					rx_nxt = RX_STOP;
				else if (pre_sync)
				begin
					rx_nxt = RX_HEAD;
					e_rsi = 1'b1;
				end
				else if (expire)
				begin
					rx_nxt = RX_BODY;
					e_rsc = 1'b1;
					e_tmo = 1'b1;
				end
			RX_HEAD:
				if (cmd[CMD_RX_END])
					rx_nxt = RX_STOP;
				else if (hdr_done)
				begin
					rx_nxt = RX_BODY;
					e_rsc = 1'b1;
					cap = 1'b1;
				end
				else if (expire)
				begin
					rx_nxt = RX_BODY;
					e_rsc = 1'b1;
					e_tmo = 1'b1;
				end
			RX_BODY:
				if (cmd[CMD_RX_END])
					rx_nxt = RX_STOP;
				else if (frame_done)
					e_rei = 1'b1;
			RX_STOP:
				if (rx_quiet)
				begin
					rx_nxt = RX_IDLE;
					e_rec = 1'b1;
				end
			default: rx_nxt = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rx_st_r <= RX_IDLE;
		else
			rx_st_r <= rx_nxt;
	end
	assign rx_search = (rx_st_r == RX_SEEK) || (rx_st_r == RX_HEAD) || (rx_st_r == RX_BODY);

	assign tmo_load = cmd[CMD_RX_START] && !cmd[CMD_RX_END]
		&& ((rx_st_r == RX_IDLE) || (rx_st_r == RX_SEEK));
	assign expire = (tmo_cnt_r == '0) && ((rx_st_r == RX_SEEK) || (rx_st_r == RX_HEAD));
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tmo_cnt_r <= '0;
		else if (tmo_load)
			tmo_cnt_r <= tmo_cfg_r;
		else if (!expire && ((rx_st_r == RX_SEEK) || (rx_st_r == RX_HEAD)))
			tmo_cnt_r <= tmo_cnt_r - 1'b1;
	end

	ptc_rxvec u_vec
	(
		.clk          (clk),
		.rst          (rst),
		.cap          (cap),
		.hdr_length   (hdr_length),
		.hdr_rate     (hdr_rate),
		.hdr_burst    (hdr_burst),
		.hdr_pre_kind (hdr_pre_kind),
		.hdr_tfc      (hdr_tfc),
		.hdr_bg_low   (hdr_bg_low),
		.hdr_octets   (hdr_octets),
		.hdr_hcs_ok   (hdr_hcs_ok),
		.hdr_rate_ok  (hdr_rate_ok),
		.hdr_strength (hdr_strength),
		.hdr_quality  (hdr_quality),
		.vec          (vec.src)
	);

	////////////////////////////////////////////////////////////////////////
	// Channel assessment
	// run flag
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cca_run_r <= 1'b0;
		else if (cmd[CMD_CCA_END])
			cca_run_r <= 1'b0;
		else if (cmd[CMD_CCA_START])
			cca_run_r <= 1'b1;
	end

	// Confirms wait one cycle so the status is settled first
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cca_sta_pend_r <= 1'b0;
			cca_end_pend_r <= 1'b0;
		end
		else
		begin
			cca_sta_pend_r <= cmd[CMD_CCA_START] && !cmd[CMD_CCA_END];
			cca_end_pend_r <= cmd[CMD_CCA_END];
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			chan_r <= CHAN_CLEAR;
		else if (cca_run_r)
			chan_r <= cca_busy ? CHAN_BUSY : CHAN_CLEAR;
	end
	assign cca_run = cca_run_r;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_halt;
		cmd[CMD_TX_END] ##1 tx_halt_r;
	endsequence
	a_tx_halt: assert property (cmd[CMD_TX_END] |-> s_halt)
		else $error("transmit halt not raised");
	a_tx_cfm_quiet: assert property ($rose(sticky_r[EV_TX_END_CFM])
		|-> $past(tx_quiet) && $past(tx_halt_r))
		else $error("transmit end confirm before quiet");
	a_rx_seek: assert property (rx_st_r == RX_IDLE && cmd[CMD_RX_START]
		&& !cmd[CMD_RX_END] |=> rx_st_r == RX_SEEK && rx_search)
		else $error("search not started");
	a_rx_sync: assert property (rx_st_r == RX_SEEK && pre_sync
		&& !cmd[CMD_RX_END] |=> sticky_r[EV_RX_START_IND] && rx_st_r == RX_HEAD)
		else $error("start indication missing");
	a_rx_hdr_cfm: assert property (rx_st_r == RX_HEAD && hdr_done
		&& !cmd[CMD_RX_END] |=> sticky_r[EV_RX_START_CFM] && rx_st_r == RX_BODY)
		else $error("start confirm missing after header");
	a_rx_stop: assert property (rx_st_r != RX_STOP && cmd[CMD_RX_END]
		|=> rx_st_r == RX_STOP && !rx_search)
		else $error("reception not stopped");
	a_rx_end_ind: assert property (rx_st_r == RX_BODY && frame_done
		&& !cmd[CMD_RX_END] |=> sticky_r[EV_RX_END_IND])
		else $error("end indication missing");
	a_rx_end_cfm: assert property ($rose(sticky_r[EV_RX_END_CFM])
		|-> $past(rx_quiet) && $past(rx_st_r) == RX_STOP)
		else $error("end confirm while receiving");
	a_rx_timeout: assert property (rx_st_r == RX_SEEK && tmo_cnt_r == '0
		&& !pre_sync && !cmd[CMD_RX_END] |=> rx_st_r == RX_BODY
		&& sticky_r[EV_RX_TMO] && sticky_r[EV_RX_START_CFM])
		else $error("timeout not taken");

	sequence s_cca_go;
		cmd[CMD_CCA_START] && !cmd[CMD_CCA_END] ##1 cca_run_r;
	endsequence
	a_cca_start: assert property (s_cca_go |=> sticky_r[EV_CCA_STA_CFM])
		else $error("assessment start confirm missing");
	a_cca_track: assert property (cca_run_r |=> chan_r == $past(cca_busy))
		else $error("channel status not tracking");
	a_cca_end: assert property (cmd[CMD_CCA_END]
		|=> !cca_run_r ##1 sticky_r[EV_CCA_END_CFM])
		else $error("assessment end not confirmed");
endmodule
`default_nettype wire

// [dv/ptc_radio_model.sv]
// Radio front end model: reports transmitter and receiver stopped after a delay
`default_nettype none
module ptc_radio_model
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic tx_halt,
	input  wire logic rx_search,
	output logic      tx_quiet,
	output logic      rx_quiet
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] tx_cnt_r;
	logic [3:0] rx_cnt_r;
	logic [3:0] dly;
	////////////////////////////////////////////////////////////////////////
	// Stopping takes one or six cycles
	assign dly = slow ? 4'h6 : 4'h1;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_cnt_r <= 4'h0;
			rx_cnt_r <= 4'h0;
		end
		else
		begin
			tx_cnt_r <= !tx_halt ? 4'h0 : tx_cnt_r + 4'(tx_cnt_r != 4'hf);
			rx_cnt_r <= rx_search ? 4'h0 : rx_cnt_r + 4'(rx_cnt_r != 4'hf);
		end
	end
	assign tx_quiet = tx_halt && tx_cnt_r >= dly;
	assign rx_quiet = !rx_search && rx_cnt_r >= dly;
endmodule
`default_nettype wire

// [dv/ptc_ctrl_tb.sv]
// Bench for the radio control block: bus tasks, random receive frames, timeouts
`default_nettype none
module ptc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ptc_pkg::*;
	logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow;
	logic tx_halt, tx_quiet, rx_search, pre_sync, hdr_done, hdr_burst, hdr_pre_kind;
	logic hdr_bg_low, hdr_hcs_ok, hdr_rate_ok, frame_done, rx_quiet, cca_run, cca_busy;
	logic [7:0] s_axi_awaddr, s_axi_araddr, hdr_strength, hdr_quality;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [11:0] hdr_length;
	logic [4:0] hdr_rate;
	logic [2:0] hdr_tfc;
	logic [79:0] hdr_octets;
	logic [95:0] rv;
	int n_errors, tests_run, seed, j, k;
	ptc_ctrl #(.HDR_TMO_CYC(32'h0000_0010)) u_ptc_ctrl (.clk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tx_halt, .tx_quiet, .rx_search, .pre_sync, .hdr_done, .hdr_length,
		.hdr_rate, .hdr_burst, .hdr_pre_kind, .hdr_tfc, .hdr_bg_low, .hdr_octets, .hdr_hcs_ok,
		.hdr_rate_ok, .hdr_strength, .hdr_quality, .frame_done, .rx_quiet, .cca_run, .cca_busy);
	ptc_radio_model u_ptc_radio_model (.clk, .rst, .slow, .tx_halt, .rx_search, .tx_quiet,
		.rx_quiet);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tmo(input int n);
		if (n >= 100)
		begin
			chk(32'(n), 32'h0000_0000);
			wrap_up;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] w);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		n = 0;
		do @(posedge clk); while (!(s_axi_awready && s_axi_wready) && ++n < 50);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		do @(posedge clk); while (!s_axi_bvalid && ++n < 100);
		r = s_axi_bresp;
		tmo(n);
	endtask
	task rd(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		n = 0;
		do @(posedge clk); while (!s_axi_arready && ++n < 50);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid && ++n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		tmo(n);
	endtask
	// Clear sticky events, then issue one request
	task cmd(input logic [4:0] c);
		wr(OFF_STATUS, 32'h0000_00ff);
		wr(OFF_CTRL, {27'h0, c});
	endtask
	task poll(input int b);
		int n;
		n = 0;
		do
		begin
			rd(OFF_STATUS);
			n++;
		end
		while (!d[b] && n < 40);
		chk(d[b], 1);
		if (d[b] !== 1'b1)
			wrap_up;
	endtask
	function automatic logic [31:0] exp_v0(input logic [31:0] x, input logic b);
		return {9'h000, x[22], x[21:19], x[18] & b, b, x[16:12], x[11:0]};
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'h35f0_1560;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{pre_sync, hdr_done, frame_done, cca_busy, slow, hdr_burst, hdr_pre_kind} = 7'h00;
		{hdr_bg_low, hdr_hcs_ok, hdr_rate_ok, hdr_length, hdr_rate, hdr_tfc} = 23'h0;
		{hdr_octets, hdr_strength, hdr_quality} = 96'h0;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (j = 0; j < 2; j++)
		begin
			slow <= j[0];
			cmd(5'h02);
			rd(OFF_STATUS);
			chk(d[ST_RX_RUN], 1);
			chk(rx_search, 1);
			v = $random(seed);
			// Corner: first frame carries a clean header
			if (j == 0)
				v[24:23] = 2'h3;
			rv = {$random(seed), $random(seed), $random(seed)};
			{hdr_bg_low, hdr_tfc, hdr_pre_kind} <= v[22:18];
			{hdr_rate, hdr_length} <= v[16:0];
			{hdr_rate_ok, hdr_hcs_ok, hdr_burst} <= {v[24:23], j[0]};
			{hdr_quality, hdr_strength, hdr_octets} <= rv;
			pre_sync <= 1'b1;
			@(posedge clk);
			{pre_sync, hdr_done} <= 2'h1;
			@(posedge clk);
			hdr_done <= 1'b0;
			poll(EV_RX_START_CFM);
			chk(d[EV_RX_START_IND], 1);
			rd(OFF_RXV0);
			chk(d, exp_v0(v, j[0]));
			rd(OFF_RXV1);
			chk(d, {8'h00, rv[95:80], 3'h0, ~v[23], ~v[24], 3'h0});
			for (k = 0; k < 3; k++)
			begin
				rd(OFF_HDR0 + 8'(4 * k));
				chk(d, 32'(rv[79:0] >> (32 * k)));
			end
			frame_done <= 1'b1;
			@(posedge clk);
			frame_done <= 1'b0;
			poll(EV_RX_END_IND);
			cmd(5'h04);
			poll(EV_RX_END_CFM);
			chk(d[ST_RX_RUN], 0);
			chk(rx_search, 0);
		end
		wr(OFF_TMO, 32'h0000_0020);
		rd(OFF_TMO);
		chk(d, 32'h0000_0020);
		cmd(5'h02);
		poll(EV_RX_TMO);
		chk(d[EV_RX_START_CFM], 1);
		cmd(5'h04);
		poll(EV_RX_END_CFM);
		cmd(5'h04);
		poll(EV_RX_END_CFM);
		cmd(5'h01);
		rd(OFF_STATUS);
		chk(d[ST_TX_HALT], 1);
		chk(tx_halt, 1);
		chk(d[EV_TX_END_CFM], 0);
		poll(EV_TX_END_CFM);
		chk(d[ST_TX_HALT], 0);
		cca_busy <= 1'b1;
		cmd(5'h08);
		poll(EV_CCA_STA_CFM);
		chk(d[ST_CHAN], CHAN_BUSY);
		chk(cca_run, 1);
		cca_busy <= 1'b0;
		repeat (2) @(posedge clk);
		rd(OFF_STATUS);
		chk(d[ST_CHAN], CHAN_CLEAR);
		cmd(5'h10);
		poll(EV_CCA_END_CFM);
		chk(d[ST_CCA_RUN], 0);
		chk(cca_run, 0);
		rd(8'h20);
		chk(32'(r), 32'(RESP_SLVERR));
		chk(d, 32'h0000_0000);
		wr(8'h24, 32'h0000_0001);
		chk(32'(r), 32'(RESP_SLVERR));
		wrap_up;
	end
endmodule
`default_nettype wire
